//--- verilog/dtce_pkg.sv
// Purpose: Shared constants, types and carriers of the descriptor transfer engine
// Assumes: Descriptor RAM holds 256 words of 32 bits; internal bus carries 16-bit data
// Notes: Descriptor layout is three words per register set
package dtce_pkg;

    // ==========================================================================
    // Widths and sizes
    localparam int unsigned RAM_AW = 8;       // Word address into the 1 kbyte RAM
    localparam int unsigned ADDR_W = 24;      // Full address space
    localparam int unsigned DATA_W = 16;      // Unit data width
    localparam int unsigned FIFO_DEPTH = 8;   // Data path buffer depth
    localparam logic [7:0] DESC_WORDS = 8'h03; // Words per register set

    // ==========================================================================
    // Mode register A field positions
    localparam int unsigned MA_SRC_MODE = 6;  // Bits 7:6 source pointer mode
    localparam int unsigned MA_DST_MODE = 4;  // Bits 5:4 destination pointer mode
    localparam int unsigned MA_XFER_MODE = 2; // Bits 3:2 transfer mode
    localparam int unsigned MA_AREA_SIDE = 1; // Area side select
    localparam int unsigned MA_UNIT_SIZE = 0; // Unit size select
    // Mode register B field positions
    localparam int unsigned MB_CHAIN = 7;     // Chain enable
    localparam int unsigned MB_IRQ_EVERY = 6; // Interrupt on every transfer

    // ==========================================================================
    // Encodings
    localparam logic [1:0] XMODE_NORMAL = 2'h0;
    localparam logic [1:0] XMODE_REPEAT = 2'h1;
    localparam logic [1:0] XMODE_BLOCK = 2'h2;
    localparam logic [1:0] AMODE_INC = 2'h2;
    localparam logic [1:0] AMODE_DEC = 2'h3;

    // Reset value of working registers and outputs
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [23:0] RST_ADDR = 24'h000000;
    localparam logic [15:0] RST_COUNT = 16'h0000;

    // ==========================================================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_GRANT = 3'b001,
        ST_LOAD = 3'b010,
        ST_READ = 3'b011,
        ST_WRITE = 3'b100,
        ST_WBACK = 3'b101,
        ST_FINISH = 3'b110
    } dtce_state_e;

    // Internal bus master request
    typedef struct packed {
        logic rd;
        logic wr;
        logic word;
        logic [23:0] addr;
        logic [15:0] wdata;
    } dtce_bus_s;

    // Descriptor RAM port
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } dtce_ram_s;

    // Working register set
    typedef struct packed {
        logic [7:0] mode_reg_a;
        logic [7:0] mode_reg_b;
        logic [23:0] source_pointer;
        logic [23:0] dest_pointer;
        logic [15:0] primary_count;
        logic [15:0] block_count;
    } dtce_regs_s;

endpackage

//--- verilog/dtce_engine.sv
// Purpose: Descriptor transfer engine with bus arbiter and data FIFO
// Assumes: Bus requests hold until a one-cycle ack; RAM read data follows one cycle later
// Notes: Working registers have no CPU port; they live in RAM between activations
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Data FIFO between the read and write halves of a unit move
module dtce_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];      // Storage
    logic [PW:0] wp_q, rp_q;            // Pointers with wrap bit
    logic push, pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // Full when pointers differ only in the wrap bit
    assign in_ready = !((wp_q[PW] != rp_q[PW]) && (wp_q[PW-1:0] == rp_q[PW-1:0]));
    assign out_valid = (wp_q != rp_q);
    assign out_data = mem[rp_q[PW-1:0]];

    // Pointer update
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end

    // Storage needs no reset; empty slots are never read out
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q[PW-1:0]] <= in_data;
        end
    end
endmodule

// Function
// - Start on enabled interrupt or software request
// - Load set from RAM, transfer, write back
// - 32-bit RAM path, one word per state
// - Working registers hidden from CPU
// - Source pointer fixed, increments or decrements
// - Destination pointer fixed, increments or decrements
// - Mode field: normal, repeat, block
// - Area side picks destination or source
// - Size bit selects byte or word
// - Chain enable loads next set immediately
// - Chained set skips end check and clears
// - Interrupt select: at end or every transfer
// - Reserved mode bits have no effect
// - Source pointer 24 bits, even for words
// - Destination pointer 24 bits, even for words
// - Normal mode: 16-bit count to zero
// - Repeat/block: low byte counts, reloads high
// - Block count decrements, ends at zero
// - Arbiter favours controller over CPU
// - Request bus, wait grant before cycles
module dtce_engine (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic onchip_ram_enable,
    input wire logic irq_act_req,
    input wire logic [7:0] irq_act_base,
    input wire logic sw_act_req,
    input wire logic [7:0] sw_act_base,
    input wire logic cpu_bus_req,
    input wire logic cpu_cycle_active,
    output logic cpu_bus_gnt,
    output dtce_pkg::dtce_bus_s bus_o,
    input wire logic bus_ack,
    input wire logic [15:0] bus_rdata,
    output dtce_pkg::dtce_ram_s ram_o,
    input wire logic [31:0] ram_rdata,
    output logic cpu_irq,
    output logic src_flag_clear,
    output logic act_enable_clear,
    output logic from_software,
    output logic busy
);
    // ==========================================================================
    // State
    typedef struct packed {
        dtce_pkg::dtce_state_e st;
        logic [1:0] idx;              // Descriptor word index
        logic [7:0] base;             // Current register set base word
        dtce_pkg::dtce_regs_s r;      // Working registers, no CPU path
        logic ended;                  // Specified count reached
        logic sw;                     // Activation came from software
        logic dgnt;                   // Bus granted to controller
        logic cgnt;                   // Bus granted to CPU
        dtce_pkg::dtce_bus_s bus;
        dtce_pkg::dtce_ram_s ram;
        logic irq;
        logic clr_src;
        logic clr_en;
    } dtce_state_s;

    dtce_state_s s_q, s_d;
    logic f_in_ready, f_out_valid, f_out_ready, f_push;
    logic [15:0] f_out_data;
    logic dreq;                       // Controller wants the bus

    // Mode field views
    logic [1:0] xmode, smode, dmode;
    logic area_src, unit_word, chain, irq_every;
    assign xmode = s_q.r.mode_reg_a[dtce_pkg::MA_XFER_MODE +: 2];
    assign smode = s_q.r.mode_reg_a[dtce_pkg::MA_SRC_MODE +: 2];
    assign dmode = s_q.r.mode_reg_a[dtce_pkg::MA_DST_MODE +: 2];
    assign area_src = s_q.r.mode_reg_a[dtce_pkg::MA_AREA_SIDE];
    assign unit_word = s_q.r.mode_reg_a[dtce_pkg::MA_UNIT_SIZE];
    assign chain = s_q.r.mode_reg_b[dtce_pkg::MB_CHAIN];
    assign irq_every = s_q.r.mode_reg_b[dtce_pkg::MB_IRQ_EVERY];
    // Mode register B bits 5:0 are carried through untouched and read nowhere

    // Pointer step after a unit: fixed, up or down by 1 or 2
    function automatic logic [23:0] step_ptr(input logic [23:0] a, input logic [1:0] m,
                                             input logic w);
        logic [23:0] st;
        st = w ? 24'h000002 : 24'h000001;
        if (m == dtce_pkg::AMODE_INC) begin
            step_ptr = a + st;
        end else if (m == dtce_pkg::AMODE_DEC) begin
            step_ptr = a - st;
        end else begin
            step_ptr = a;
        end
    endfunction

    // Undo one whole pass over the area
    function automatic logic [23:0] rewind_ptr(input logic [23:0] a, input logic [1:0] m,
                                               input logic [23:0] span);
        if (m == dtce_pkg::AMODE_INC) begin
            rewind_ptr = a - span;
        end else if (m == dtce_pkg::AMODE_DEC) begin
            rewind_ptr = a + span;
        end else begin
            rewind_ptr = a;
        end
    endfunction

    // ==========================================================================
    // Data buffer: read data queues here until the write side drains it
    assign f_push = (s_q.st == dtce_pkg::ST_READ) && s_q.bus.rd && bus_ack;
    assign f_out_ready = (s_q.st == dtce_pkg::ST_WRITE) && !s_q.bus.wr;

    dtce_fifo #(.WIDTH(dtce_pkg::DATA_W), .DEPTH(dtce_pkg::FIFO_DEPTH)) u_fifo (
        .clk(core_clk),
        .rstn(rstn),
        .in_valid(f_push),
        .in_ready(f_in_ready),
        .in_data(bus_rdata),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    // ==========================================================================
    // Next state
    always_comb begin
        logic [8:0] reload_n;
        logic [23:0] span, nsp, ndp;
        logic [7:0] run;
        logic [15:0] cb_n;
        reload_n = '0;
        span = '0;
        nsp = '0;
        ndp = '0;
        run = '0;
        cb_n = '0;
        s_d = s_q;
        // Pulses last one cycle
        s_d.irq = 1'b0;
        s_d.clr_src = 1'b0;
        s_d.clr_en = 1'b0;
        s_d.ram.rd = 1'b0;
        s_d.ram.wr = 1'b0;

        // Arbiter: hand over only between bus cycles, controller first
        if (!cpu_cycle_active && !s_q.bus.rd && !s_q.bus.wr) begin
            s_d.dgnt = dreq;
            s_d.cgnt = cpu_bus_req && !dreq;
        end

        unique case (s_q.st)
            // Wait for an activation; RAM must be on since sets live there
            dtce_pkg::ST_IDLE: begin
                if (onchip_ram_enable && (irq_act_req || sw_act_req)) begin
                    s_d.st = dtce_pkg::ST_GRANT;
                    s_d.sw = !irq_act_req;
                    s_d.base = irq_act_req ? irq_act_base : sw_act_base;
                end
            end
            // No cycle of any kind before the grant
            dtce_pkg::ST_GRANT: begin
                if (s_q.dgnt) begin
                    s_d.st = dtce_pkg::ST_LOAD;
                    s_d.idx = 2'h0;
                    s_d.ram.rd = 1'b1;
                    s_d.ram.addr = s_q.base;
                end
            end
            // One 32-bit word per state; RAM data trails its read pulse by one state,
            // so the word issued at index n is captured at index n+1
            dtce_pkg::ST_LOAD: begin
                s_d.idx = s_q.idx + 2'h1;
                unique case (s_q.idx)
                    2'h0: begin
                        // First word still in flight; nothing to capture yet
                    end
                    2'h1: begin
                        s_d.r.mode_reg_a = ram_rdata[31:24];
                        s_d.r.source_pointer = ram_rdata[23:0];
                    end
                    2'h2: begin
                        s_d.r.mode_reg_b = ram_rdata[31:24];
                        s_d.r.dest_pointer = ram_rdata[23:0];
                    end
                    2'h3: begin
                        s_d.r.primary_count = ram_rdata[31:16];
                        s_d.r.block_count = ram_rdata[15:0];
                    end
                endcase
                if (s_q.idx == 2'h3) begin
                    s_d.st = dtce_pkg::ST_READ;
                end else if (s_q.idx != 2'h2) begin
                    s_d.ram.rd = 1'b1;
                    s_d.ram.addr = s_q.ram.addr + 8'h01;
                end
            end
            // Source read; waits for room so the buffer never overflows
            dtce_pkg::ST_READ: begin
                if (!s_q.bus.rd && f_in_ready) begin
                    s_d.bus.rd = 1'b1;
                    s_d.bus.word = unit_word;
                    s_d.bus.addr = s_q.r.source_pointer;
                end else if (s_q.bus.rd && bus_ack) begin
                    s_d.bus.rd = 1'b0;
                    s_d.st = dtce_pkg::ST_WRITE;
                end
            end
            // Destination write, then pointer and count update
            dtce_pkg::ST_WRITE: begin
                if (!s_q.bus.wr && f_out_valid) begin
                    s_d.bus.wr = 1'b1;
                    s_d.bus.word = unit_word;
                    s_d.bus.addr = s_q.r.dest_pointer;
                    s_d.bus.wdata = f_out_data;
                end else if (s_q.bus.wr && bus_ack) begin
                    s_d.bus.wr = 1'b0;
                    nsp = step_ptr(s_q.r.source_pointer, smode, unit_word);
                    ndp = step_ptr(s_q.r.dest_pointer, dmode, unit_word);
                    s_d.st = dtce_pkg::ST_WBACK;
                    s_d.idx = 2'h0;
                    s_d.ended = 1'b0;
                    if (xmode == dtce_pkg::XMODE_NORMAL) begin
                        s_d.r.primary_count = s_q.r.primary_count - 16'h0001;
                        s_d.ended = (s_q.r.primary_count == 16'h0001);
                    end else begin
                        run = s_q.r.primary_count[7:0] - 8'h01;
                        s_d.r.primary_count[7:0] = run;
                        if (run == 8'h00) begin
                            // Reload count and return area side to its start
                            s_d.r.primary_count[7:0] = s_q.r.primary_count[15:8];
                            reload_n = (s_q.r.primary_count[15:8] == 8'h00) ? 9'h100 :
                                {1'b0, s_q.r.primary_count[15:8]};
                            span = unit_word ? {14'h0000, reload_n, 1'b0} :
                                {15'h0000, reload_n};
                            if (area_src) begin
                                nsp = rewind_ptr(nsp, smode, span);
                            end else begin
                                ndp = rewind_ptr(ndp, dmode, span);
                            end
                            if (xmode == dtce_pkg::XMODE_BLOCK) begin
                                cb_n = s_q.r.block_count - 16'h0001;
                                s_d.r.block_count = cb_n;
                                s_d.ended = (cb_n == 16'h0000);
                            end
                        end else if (xmode == dtce_pkg::XMODE_BLOCK) begin
                            s_d.st = dtce_pkg::ST_READ; // Rest of the block
                        end
                    end
                    s_d.r.source_pointer = nsp;
                    s_d.r.dest_pointer = ndp;
                end
            end
            // Write updated set back, one word per state
            dtce_pkg::ST_WBACK: begin
                s_d.ram.wr = 1'b1;
                s_d.ram.addr = s_q.base + {6'h00, s_q.idx};
                unique case (s_q.idx)
                    2'h0: s_d.ram.wdata = {s_q.r.mode_reg_a, s_q.r.source_pointer};
                    2'h1: s_d.ram.wdata = {s_q.r.mode_reg_b, s_q.r.dest_pointer};
                    default: s_d.ram.wdata = {s_q.r.primary_count, s_q.r.block_count};
                endcase
                s_d.idx = s_q.idx + 2'h1;
                if (s_q.idx == 2'h2) begin
                    s_d.st = dtce_pkg::ST_FINISH;
                end
            end
            // Chain on, or report and release
            dtce_pkg::ST_FINISH: begin
                if (chain) begin
                    // No end check and no clears on a chained set
                    s_d.base = s_q.base + dtce_pkg::DESC_WORDS;
                    s_d.st = dtce_pkg::ST_LOAD;
                    s_d.idx = 2'h0;
                    s_d.ram.rd = 1'b1;
                    s_d.ram.addr = s_q.base + dtce_pkg::DESC_WORDS;
                end else begin
                    s_d.st = dtce_pkg::ST_IDLE;
                    s_d.irq = irq_every || s_q.ended;
                    s_d.clr_en = s_q.ended;
                    s_d.clr_src = !irq_every && !s_q.ended;
                end
            end
            default: s_d.st = dtce_pkg::ST_IDLE;
        endcase
    end

    // Bus stays requested for the whole activation
    assign dreq = (s_q.st != dtce_pkg::ST_IDLE);

    // Register the state
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{st: dtce_pkg::ST_IDLE, idx: 2'h0, base: 8'h00,
                     r: '{dtce_pkg::RST_MODE, dtce_pkg::RST_MODE, dtce_pkg::RST_ADDR,
                          dtce_pkg::RST_ADDR, dtce_pkg::RST_COUNT, dtce_pkg::RST_COUNT},
                     ended: 1'b0, sw: 1'b0, dgnt: 1'b0, cgnt: 1'b0,
                     bus: '0, ram: '0, irq: 1'b0, clr_src: 1'b0, clr_en: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign bus_o = s_q.bus;
    assign ram_o = s_q.ram;
    assign cpu_bus_gnt = s_q.cgnt;
    assign cpu_irq = s_q.irq;
    assign src_flag_clear = s_q.clr_src;
    assign act_enable_clear = s_q.clr_en;
    assign from_software = s_q.sw;
    assign busy = dreq;

    // ==========================================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    logic unit_done;
    assign unit_done = (s_q.st == dtce_pkg::ST_WRITE) && s_q.bus.wr && bus_ack;

    sequence load_start_s;
        (s_q.st == dtce_pkg::ST_GRANT) && s_q.dgnt;
    endsequence
    sequence three_reads_s;
        ram_o.rd [*3] ##1 !ram_o.rd;
    endsequence
    sequence finish_plain_s;
        (s_q.st == dtce_pkg::ST_FINISH) && !chain;
    endsequence

    a_cycle_needs_grant: assert property ((bus_o.rd || bus_o.wr) |-> s_q.dgnt)
        else $error("Bus cycle without grant");
    a_ctrl_wins_bus: assert property (
        (dreq && cpu_bus_req && !cpu_cycle_active && !bus_o.rd && !bus_o.wr)
        |=> (s_q.dgnt && !cpu_bus_gnt))
        else $error("CPU granted over controller");
    a_load_three_words: assert property (load_start_s |=> three_reads_s)
        else $error("Set load is not three back to back words");
    a_every_irq: assert property (finish_plain_s and irq_every
        |=> (cpu_irq && !src_flag_clear))
        else $error("Every-transfer interrupt wrong");
    a_end_irq: assert property (finish_plain_s and !irq_every
        |=> (cpu_irq == act_enable_clear) && (src_flag_clear != cpu_irq))
        else $error("End interrupt or flag clear wrong");
    a_chain_quiet: assert property (((s_q.st == dtce_pkg::ST_FINISH) && chain)
        |=> (!cpu_irq && !src_flag_clear && !act_enable_clear && ram_o.rd))
        else $error("Chained set cleared or did not reload");
    a_src_inc_step: assert property ((unit_done && smode == dtce_pkg::AMODE_INC &&
        xmode == dtce_pkg::XMODE_NORMAL) |=> (s_q.r.source_pointer ==
        $past(s_q.r.source_pointer) + (unit_word ? 24'h000002 : 24'h000001)))
        else $error("Source increment wrong");
    a_dst_fixed: assert property ((unit_done && !dmode[1])
        |=> $stable(s_q.r.dest_pointer))
        else $error("Fixed destination moved");
    a_normal_count: assert property ((unit_done && xmode == dtce_pkg::XMODE_NORMAL)
        |=> (s_q.r.primary_count == $past(s_q.r.primary_count) - 16'h0001))
        else $error("Normal count not decremented");
    a_wback_follows: assert property ((unit_done && xmode != dtce_pkg::XMODE_BLOCK)
        |=> ##1 ram_o.wr [*3])
        else $error("Write back missing");
endmodule

`default_nettype wire

//--- dv/dtce_far_model.sv
// Purpose: Far side of the engine: descriptor RAM and internal bus targets
// Assumes: Bus request held until ack; RAM answers the cycle after a read pulse
// Notes: Idle data lines toggle so a stale value never passes for an answer
`timescale 1ns/1ns
`default_nettype none
module dtce_far_model (
    input wire logic core_clk,
    input wire dtce_pkg::dtce_bus_s bus_o,
    output logic bus_ack,
    output logic [15:0] bus_rdata,
    input wire dtce_pkg::dtce_ram_s ram_o,
    output logic [31:0] ram_rdata,
    input wire logic [1:0] lat
);
    logic [31:0] ram [0:255]; // Register sets, one 32-bit word per state
    logic [15:0] mem [0:255]; // Bus targets, indexed by the low address byte
    logic [1:0] wait_q = 2'h0; // Cycles spent stalling the current bus cycle
    initial bus_ack = 1'b0;
    initial bus_rdata = 16'h5a5a;
    initial ram_rdata = 32'h5a5a5a5a;
    // ==========================================
    // RAM port: write at once, read data in the next cycle
    always @(posedge core_clk) begin
        if (ram_o.wr) ram[ram_o.addr] <= ram_o.wdata;
        ram_rdata <= ram_o.rd ? ram[ram_o.addr] : ~ram_rdata;
    end
    // ==========================================
    // Bus: ack after lat stall cycles; never twice in a row, so a late drop is caught
    always @(posedge core_clk) begin
        bus_ack <= 1'b0;
        bus_rdata <= ~bus_rdata;
        if (!bus_ack && (bus_o.rd || bus_o.wr)) begin
            if (wait_q == lat) begin
                bus_ack <= 1'b1;
                wait_q <= 2'h0;
                if (bus_o.rd) bus_rdata <= mem[bus_o.addr[7:0]];
                if (bus_o.wr) begin
                    mem[bus_o.addr[7:0]] <= bus_o.word ? bus_o.wdata : {8'h00, bus_o.wdata[7:0]};
                end
            end else wait_q <= wait_q + 2'h1;
        end
    end
endmodule
`default_nettype wire

//--- dv/descriptor_transfer_engine_bench.sv
// Purpose: Self-checking bench of the transfer engine
// Assumes: Register sets are placed in the model RAM directly
// Notes: Bus memory holds {a, ~a} at address a, so moved data is predictable
`timescale 1ns/1ns
`default_nettype none
module descriptor_transfer_engine_bench;
    logic core_clk = 1'b0, rstn = 1'b0, onchip_ram_enable = 1'b0, cpu_cycle_active = 1'b0;
    logic irq_act_req = 1'b0, sw_act_req = 1'b0;
    logic [7:0] irq_act_base = 8'h00, sw_act_base = 8'h00;
    logic [1:0] lat = 2'h0; // Bus stall cycles of the model
    logic bus_ack, cpu_bus_gnt, cpu_irq, src_flag_clear, act_enable_clear, from_software, busy;
    logic [15:0] bus_rdata;
    logic [31:0] ram_rdata;
    dtce_pkg::dtce_bus_s bus_o;
    dtce_pkg::dtce_ram_s ram_o;
    int failures = 0, total_checks = 0, n_irq, n_sfc, n_aec;
    always #5 core_clk = ~core_clk;
    dtce_engine uut (.core_clk(core_clk), .rstn(rstn), .onchip_ram_enable(onchip_ram_enable),
        .irq_act_req(irq_act_req), .irq_act_base(irq_act_base), .sw_act_req(sw_act_req),
        .sw_act_base(sw_act_base), .cpu_bus_req(1'b1), .cpu_cycle_active(cpu_cycle_active),
        .cpu_bus_gnt(cpu_bus_gnt), .bus_o(bus_o), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
        .ram_o(ram_o), .ram_rdata(ram_rdata), .cpu_irq(cpu_irq), .src_flag_clear(src_flag_clear),
        .act_enable_clear(act_enable_clear), .from_software(from_software), .busy(busy));
    dtce_far_model far (.core_clk(core_clk), .bus_o(bus_o), .bus_ack(bus_ack),
        .bus_rdata(bus_rdata), .ram_o(ram_o), .ram_rdata(ram_rdata), .lat(lat));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ==========================================
    // Monitor: count pulses; engine bus cycles must own the bus alone
    always @(negedge core_clk) begin
        n_irq += int'(cpu_irq === 1'b1);
        n_sfc += int'(src_flag_clear === 1'b1);
        n_aec += int'(act_enable_clear === 1'b1);
        if (bus_o.rd || bus_o.wr) check("cpu grant", 32'h0, {31'h0, cpu_bus_gnt});
        if (bus_o.rd || bus_o.wr) check("cpu cycle", 32'h0, {31'h0, cpu_cycle_active});
    end
    task automatic desc(input logic [7:0] b, ma, mb, input logic [23:0] s, d,
                        input logic [15:0] ca, cb);
        far.ram[b] = {ma, s};
        far.ram[b + 8'h01] = {mb, d};
        far.ram[b + 8'h02] = {ca, cb};
    endtask
    // One activation; a CPU cycle may hold the bus for the first hold cycles
    task automatic act(input logic [7:0] b, input logic irq, sw, input int hold);
        n_irq = 0;
        n_sfc = 0;
        n_aec = 0;
        @(posedge core_clk);
        irq_act_base <= b;
        sw_act_base <= irq ? b + 8'h40 : b;
        irq_act_req <= irq;
        sw_act_req <= sw;
        cpu_cycle_active <= hold != 0;
        @(posedge core_clk);
        irq_act_req <= 1'b0;
        sw_act_req <= 1'b0;
        repeat (hold) @(posedge core_clk);
        cpu_cycle_active <= 1'b0;
        // Busy only shows once the acceptance edge has settled
        @(negedge core_clk);
        for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge core_clk);
        repeat (2) @(negedge core_clk);
        check("busy", 32'h0, {31'h0, busy});
        check("from_software", {31'h0, sw & !irq}, {31'h0, from_software});
    endtask
    task automatic wb(input logic [7:0] b, input logic [23:0] s, d, input logic [15:0] ca, cb);
        check("source_pointer", {8'h00, s}, {8'h00, far.ram[b][23:0]});
        check("dest_pointer", {8'h00, d}, {8'h00, far.ram[b + 8'h01][23:0]});
        check("counts", {ca, cb}, far.ram[b + 8'h02]);
    endtask
    task automatic pl(input int i, s, a);
        check("irq/flag/enable pulses", {i[7:0], s[7:0], a[7:0], 8'h00},
              {n_irq[7:0], n_sfc[7:0], n_aec[7:0], 8'h00});
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        for (int i = 0; i < 256; i++) far.mem[i] = {i[7:0], ~i[7:0]};
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        act(8'h00, 1'b1, 1'b0, 0);
        check("refused while RAM off", 32'h40, {24'h0, far.mem[8'h40][15:8]});
        pl(0, 0, 0);
        onchip_ram_enable <= 1'b1;
        desc(8'h00, 8'hb1, 8'h3f, 24'h10, 24'h40, 16'h0002, 16'h0);
        act(8'h00, 1'b1, 1'b1, 0);
        wb(8'h00, 24'h12, 24'h3e, 16'h0001, 16'h0);
        check("word moved", 32'h10ef, {16'h0, far.mem[8'h40]});
        pl(0, 1, 0);
        desc(8'h03, 8'h20, 8'h00, 24'h20, 24'h50, 16'h0001, 16'h0);
        act(8'h03, 1'b0, 1'b1, 0);
        wb(8'h03, 24'h20, 24'h51, 16'h0000, 16'h0);
        check("byte moved", 32'h00df, {16'h0, far.mem[8'h50]});
        pl(1, 0, 1);
        desc(8'h06, 8'h96, 8'h40, 24'h30, 24'ha0, 16'h0301, 16'h0);
        act(8'h06, 1'b0, 1'b1, 0);
        wb(8'h06, 24'h2e, 24'ha0, 16'h0303, 16'h0);
        check("repeat byte moved", 32'h00cf, {16'h0, far.mem[8'ha0]});
        pl(1, 0, 0);
        lat <= 2'h2;
        desc(8'h09, 8'haa, 8'h00, 24'h60, 24'h70, 16'h0202, 16'h0003);
        act(8'h09, 1'b1, 1'b0, 3);
        wb(8'h09, 24'h60, 24'h72, 16'h0202, 16'h0002);
        check("block unit 2", 32'h009e, {16'h0, far.mem[8'h71]});
        pl(0, 1, 0);
        desc(8'h0c, 8'hc0, 8'h80, 24'h80, 24'h90, 16'h0005, 16'h0);
        desc(8'h0f, 8'h21, 8'h00, 24'h84, 24'h94, 16'h0001, 16'h0);
        act(8'h0c, 1'b1, 1'b0, 0);
        wb(8'h0c, 24'h7f, 24'h90, 16'h0004, 16'h0);
        wb(8'h0f, 24'h84, 24'h96, 16'h0000, 16'h0);
        pl(1, 0, 1);
        conclude();
    end
    initial begin
        #100000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
